//--- inc/ocpwm_pkg.sv
// Package for the output compare and PWM channel: register map, fields, modes.
package ocpwm_pkg;
  // Register offsets on the plain register port.
  localparam logic [3:0] OCPWM_CTRL_OFS = 4'h0;
  localparam logic [3:0] OCPWM_PRI_OFS = 4'h1;
  localparam logic [3:0] OCPWM_SEC_OFS = 4'h2;
  localparam logic [3:0] OCPWM_STAT_OFS = 4'h3;
  localparam logic [3:0] OCPWM_MASK_OFS = 4'h4;
  localparam logic [3:0] OCPWM_PIN_OFS = 4'h5;
  // Control register field positions.
  localparam int OCPWM_MODE_LSB = 0;
  localparam int OCPWM_TSEL_BIT = 3;
  localparam int OCPWM_FLT_BIT = 4;
  // Reset values.
  localparam logic [15:0] OCPWM_CTRL_RST = 16'h0000;
  localparam logic [15:0] OCPWM_CMP_RST = 16'h0000;
  localparam logic [15:0] OCPWM_TMR_START = 16'h0000;
  localparam logic [2:0] OCPWM_IRQ_RST = 3'h0;
  // Status and mask bit positions: match, period restart, fault.
  localparam int OCPWM_EV_MATCH = 0;
  localparam int OCPWM_EV_PERIOD = 1;
  localparam int OCPWM_EV_FAULT = 2;
  localparam int OCPWM_EV_N = 3;

  // Compare mode field codes.
  typedef enum logic [2:0] {
    OCPWM_M_OFF = 3'h0,
    OCPWM_M_LOW = 3'h1,
    OCPWM_M_HIGH = 3'h2,
    OCPWM_M_TOG = 3'h3,
    OCPWM_M_SINGLE = 3'h4,
    OCPWM_M_CONT = 3'h5,
    OCPWM_M_PWM = 3'h6,
    OCPWM_M_PWMF = 3'h7
  } ocpwm_mode_t;

  // Single pulse sequencer states, one-hot.
  typedef enum logic [2:0] {
    OCPWM_S_ARMED = 3'b001,
    OCPWM_S_PULSE = 3'b010,
    OCPWM_S_DONE = 3'b100
  } ocpwm_sp_t;

  // Timer view taken from one of the two timers.
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] period;
    logic run;
  } ocpwm_tmr_t;

  // Register port request.
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } ocpwm_req_t;
endpackage : ocpwm_pkg

//--- logic/ocpwm_tmr_mux.sv
// Timer selection multiplexer with a registered timer view.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_tmr_mux
  import ocpwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic sel_i,
  input wire ocpwm_tmr_t tmr_a_i,
  input wire ocpwm_tmr_t tmr_b_i,
  output ocpwm_tmr_t tmr_o
);
  // The view is registered so every compare looks at one stable copy.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tmr_o <= '0;
    end else if (ce_i) begin
      tmr_o <= sel_i ? tmr_b_i : tmr_a_i; // RQ1
    end
  end
endmodule : ocpwm_tmr_mux
`default_nettype wire

//--- logic/ocpwm_irq.sv
// Sticky event status, mask and level interrupt output.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_irq
  import ocpwm_pkg::*;
#(
  parameter int N = OCPWM_EV_N
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [N-1:0] ev_i,
  input wire logic [N-1:0] clr_i,
  input wire logic mask_wr_i,
  input wire logic [N-1:0] mask_i,
  output logic [N-1:0] stat_o,
  output logic [N-1:0] mask_o,
  output logic irq_o
);
  // Set wins over a write-one clear arriving in the same cycle.
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          stat_o[g] <= 1'b0;
        end else if (ce_i) begin
          stat_o[g] <= ev_i[g] | (stat_o[g] & ~clr_i[g]);
        end
      end
    end
  endgenerate

  // Mask register and registered interrupt level.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mask_o <= N'(OCPWM_IRQ_RST);
      irq_o <= 1'b0;
    end else if (ce_i) begin
      if (mask_wr_i) begin
        mask_o <= mask_i;
      end
      irq_o <= |(stat_o & mask_o);
    end
  end
endmodule : ocpwm_irq
`default_nettype wire

//--- logic/ocpwm_chan.sv
// Output compare channel with simple, dual-compare and PWM modes.
// Function
// RQ1: Timer select bit 3 picks second timer; clear picks the first.
// RQ2: Mode 001 drives low, 010 high, 011 toggles on match.
// RQ3: Simple modes compare primary register with selected counting timer.
// RQ4: A timer wrap before the match leaves the pin unchanged.
// RQ5: Mode 100 gives one pulse, mode 101 a pulse train.
// RQ6: Primary is start time, secondary stop time, from count zero.
// RQ7: Software sets period not below secondary before dual modes.
// RQ8: Single pulse set up with timer stopped, then run bit set.
// RQ9: Writing mode 100 again re-arms a further single pulse.
// RQ10: Mode 101 with timer running pulses once each period.
// RQ11: Modes 110 and 111 are PWM; 111 adds fault protection.
// RQ12: In PWM the primary is a read-only duty latch fed from secondary.
// RQ13: Software writes period, duty, mode, then runs the timer.
// RQ14: Mode 111 with low fault input makes the pin high impedance.
// RQ15: Fault flag at control bit 4 sets on detected fault.
// RQ16: High impedance holds until fault clears and mode is rewritten.
// RQ17: PWM rises at period match, falls at duty; latch loads then.
// RQ18: Dual modes rise at start, fall at stop; single stays low.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_chan
  import ocpwm_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire ocpwm_tmr_t tmr_a_i,
  input wire ocpwm_tmr_t tmr_b_i,
  input wire logic fault_n_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic pin_o,
  output logic pin_oe_o,
  output logic irq_o
);
  ocpwm_tmr_t tmr;
  ocpwm_mode_t mode_ff;
  ocpwm_sp_t sp_ff;
  logic tsel_ff;
  logic flt_ff;
  logic tri_ff;
  logic [15:0] pri_ff;
  logic [15:0] sec_ff;
  logic [OCPWM_EV_N-1:0] stat;
  logic [OCPWM_EV_N-1:0] mask;
  logic [OCPWM_EV_N-1:0] ev;
  logic [OCPWM_EV_N-1:0] clr;
  logic ctrl_wr;
  logic mode_wr;
  logic is_pwm;
  logic hit_pri;
  logic hit_sec;
  logic hit_per;
  logic fault_now;

  assign ctrl_wr = wr_i && (addr_i == OCPWM_CTRL_OFS);
  assign mode_wr = ctrl_wr;
  assign is_pwm = (mode_ff == OCPWM_M_PWM) || (mode_ff == OCPWM_M_PWMF); // RQ11
  // A match counts only while the timer runs, so a stopped timer sitting on
  // a compare value does not keep firing.
  assign hit_pri = tmr.run && (tmr.count == pri_ff); // RQ3
  assign hit_sec = tmr.run && (tmr.count == sec_ff);
  assign hit_per = tmr.run && (tmr.count == tmr.period);
  assign fault_now = (mode_ff == OCPWM_M_PWMF) && !fault_n_i; // RQ14

  // Timer selection follows the timer select bit.
  ocpwm_tmr_mux u_mux (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .sel_i(tsel_ff), // RQ1
    .tmr_a_i(tmr_a_i),
    .tmr_b_i(tmr_b_i),
    .tmr_o(tmr)
  );

  // Events: output match, period restart, fault.
  assign ev[OCPWM_EV_MATCH] = hit_pri && (mode_ff != OCPWM_M_OFF) && !is_pwm;
  assign ev[OCPWM_EV_PERIOD] = hit_per;
  assign ev[OCPWM_EV_FAULT] = fault_now;
  assign clr = (wr_i && (addr_i == OCPWM_STAT_OFS)) ?
               wdata_i[OCPWM_EV_N-1:0] : '0;

  ocpwm_irq #(
    .N(OCPWM_EV_N)
  ) u_irq (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .ev_i(ev),
    .clr_i(clr),
    .mask_wr_i(wr_i && (addr_i == OCPWM_MASK_OFS)),
    .mask_i(wdata_i[OCPWM_EV_N-1:0]),
    .stat_o(stat),
    .mask_o(mask),
    .irq_o(irq_o)
  );

  // Control register: mode field and timer select.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      mode_ff <= ocpwm_mode_t'(OCPWM_CTRL_RST[2:0]);
      tsel_ff <= OCPWM_CTRL_RST[OCPWM_TSEL_BIT];
    end else if (ce_i && ctrl_wr) begin
      mode_ff <= ocpwm_mode_t'(wdata_i[OCPWM_MODE_LSB +: 3]); // RQ2
      tsel_ff <= wdata_i[OCPWM_TSEL_BIT]; // RQ1
    end
  end

  // Fault flag: hardware set wins; a control write clears it unless mode 111
  // sees the fault input low in that same cycle.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flt_ff <= OCPWM_CTRL_RST[OCPWM_FLT_BIT];
    end else if (ce_i) begin
      if (fault_now) begin
        flt_ff <= 1'b1; // RQ15
      end else if (mode_wr) begin
        flt_ff <= 1'b0;
      end
    end
  end

  // Tri-state hold needs both the fault gone and a mode rewrite.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tri_ff <= 1'b0;
    end else if (ce_i) begin
      if (fault_now) begin
        tri_ff <= 1'b1; // RQ14
      end else if (mode_wr && fault_n_i) begin
        tri_ff <= 1'b0; // RQ16
      end
    end
  end

  // Primary register: written by software outside PWM; in PWM it is the
  // duty latch loaded from the secondary at the period match only, so a
  // duty change mid-period cannot glitch the output.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pri_ff <= OCPWM_CMP_RST;
    end else if (ce_i) begin
      if (is_pwm) begin
        if (hit_per) begin
          pri_ff <= sec_ff; // RQ12 RQ17
        end
      end else if (wr_i && (addr_i == OCPWM_PRI_OFS)) begin
        pri_ff <= wdata_i;
      end
    end
  end

  // Secondary register, always software written.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sec_ff <= OCPWM_CMP_RST;
    end else if (ce_i && wr_i && (addr_i == OCPWM_SEC_OFS)) begin
      sec_ff <= wdata_i;
    end
  end

  // Single pulse sequencer; any control register write re-arms it.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sp_ff <= OCPWM_S_ARMED;
    end else if (ce_i) begin
      if (mode_wr) begin
        sp_ff <= OCPWM_S_ARMED; // RQ9
      end else if (mode_ff == OCPWM_M_SINGLE) begin
        case (sp_ff)
          OCPWM_S_ARMED: begin
            if (hit_pri) begin
              sp_ff <= OCPWM_S_PULSE;
            end
          end
          OCPWM_S_PULSE: begin
            if (hit_sec) begin
              sp_ff <= OCPWM_S_DONE; // RQ18
            end
          end
          default: begin
            sp_ff <= OCPWM_S_DONE;
          end
        endcase
      end
    end
  end

  // Pin level. Matches act only on equality with the counting timer, so a
  // wrap before reaching the compare value changes nothing.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
    end else if (ce_i) begin
      case (mode_ff)
        OCPWM_M_LOW: begin
          if (hit_pri) begin
            pin_o <= 1'b0; // RQ2 RQ4
          end
        end
        OCPWM_M_HIGH: begin
          if (hit_pri) begin
            pin_o <= 1'b1; // RQ2
          end
        end
        OCPWM_M_TOG: begin
          if (hit_pri) begin
            pin_o <= ~pin_o; // RQ2
          end
        end
        OCPWM_M_SINGLE: begin
          if (sp_ff == OCPWM_S_ARMED && hit_pri) begin
            pin_o <= 1'b1; // RQ5 RQ6
          end else if (sp_ff == OCPWM_S_PULSE && hit_sec) begin
            pin_o <= 1'b0; // RQ18
          end
        end
        OCPWM_M_CONT: begin
          if (hit_pri) begin
            pin_o <= 1'b1; // RQ10
          end else if (hit_sec) begin
            pin_o <= 1'b0; // RQ10
          end
        end
        OCPWM_M_PWM, OCPWM_M_PWMF: begin
          if (hit_per) begin
            pin_o <= (sec_ff != OCPWM_TMR_START); // RQ17
          end else if (tmr.run && tmr.count == pri_ff) begin
            pin_o <= 1'b0; // RQ17
          end
        end
        default: begin
          pin_o <= 1'b0;
        end
      endcase
    end
  end

  // Output enable drops the cycle after a fault is seen.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      pin_oe_o <= (mode_ff != OCPWM_M_OFF) && !tri_ff && !fault_now; // RQ14
    end
  end

  // Read data stands in the cycle after the read strobe only.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 16'h0000;
    end else if (ce_i) begin
      rdata_o <= 16'h0000;
      if (rd_i) begin
        if (addr_i == OCPWM_CTRL_OFS) begin
          rdata_o <= {11'h000, flt_ff, tsel_ff, mode_ff}; // RQ15
        end else if (addr_i == OCPWM_PRI_OFS) begin
          rdata_o <= pri_ff;
        end else if (addr_i == OCPWM_SEC_OFS) begin
          rdata_o <= sec_ff;
        end else if (addr_i == OCPWM_STAT_OFS) begin
          rdata_o <= {13'h0000, stat};
        end else if (addr_i == OCPWM_MASK_OFS) begin
          rdata_o <= {13'h0000, mask};
        end else if (addr_i == OCPWM_PIN_OFS) begin
          rdata_o <= {14'h0000, pin_oe_o, pin_o};
        end
      end
    end
  end

  // Single pulse steps: start match raises, stop match lowers.
  sequence sp_start_s;
    mode_ff == OCPWM_M_SINGLE && sp_ff == OCPWM_S_ARMED && hit_pri && !wr_i;
  endsequence

  sequence sp_stop_s;
    mode_ff == OCPWM_M_SINGLE && sp_ff == OCPWM_S_PULSE && hit_sec && !wr_i;
  endsequence

  sp_rise_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ18
    (sp_start_s and ce_i) |=> pin_o)
    else $error("single pulse did not rise at start match");

  sp_fall_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ18
    (sp_stop_s and ce_i) |=> !pin_o && sp_ff == OCPWM_S_DONE)
    else $error("single pulse did not end at stop match");

  sp_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ9
    sp_ff == OCPWM_S_DONE && !wr_i && ce_i |=> $stable(pin_o))
    else $error("single pulse pin moved while not armed");

  sp_rearm_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ9
    ce_i && ctrl_wr |=> sp_ff == OCPWM_S_ARMED)
    else $error("mode write did not re-arm");

  tsel_view_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ1
    ce_i && !tsel_ff && $past(ce_i) |=> tmr == $past(tmr_a_i))
    else $error("timer view does not follow first timer");

  tog_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ2
    ce_i && mode_ff == OCPWM_M_TOG && hit_pri && !ctrl_wr
    |=> pin_o != $past(pin_o))
    else $error("toggle mode did not toggle on match");

  no_match_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ4
    ce_i && (mode_ff == OCPWM_M_LOW || mode_ff == OCPWM_M_HIGH) && !hit_pri
    |=> $stable(pin_o))
    else $error("pin changed without a compare match");

  fault_tri_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ14
    ce_i && fault_now |=> !pin_oe_o && flt_ff)
    else $error("fault did not release the pin");

  tri_hold_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ16
    ce_i && tri_ff && !ctrl_wr |=> tri_ff)
    else $error("tri-state ended without a mode rewrite");

  duty_load_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ12
    ce_i && is_pwm && hit_per |=> pri_ff == $past(sec_ff))
    else $error("duty latch not loaded at period match");

  pwm_rise_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // RQ17
    ce_i && is_pwm && hit_per && sec_ff != 16'h0000 && !ctrl_wr |=> pin_o)
    else $error("pwm output did not rise at period");
endmodule : ocpwm_chan
`default_nettype wire

//--- test/ocpwm_load.sv
// Load on the compare output pin and source of the fault input.
`timescale 1ns/10ps
`default_nettype none
module ocpwm_load (
  input wire logic mclk_i,
  input wire logic pin_i,
  input wire logic oe_i,
  input wire logic flt_i,
  output logic line_o,
  output logic fault_n_o
);
  logic last_ff;
  // Remember the last driven level so a released pin can show its inverse.
  always_ff @(posedge mclk_i) begin
    if (oe_i) begin
      last_ff <= pin_i;
    end
  end
  // No pull on the line, so an undriven pin never repeats the old level.
  assign line_o = oe_i ? pin_i : ~last_ff;
  // The fault source pulls its line low while a fault is requested.
  assign fault_n_o = ~flt_i;
endmodule : ocpwm_load
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the output compare and PWM channel.
`timescale 1ns/10ps
`default_nettype none
module tb
  import ocpwm_pkg::*;
;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic flt = 1'b0;
  logic ce = 1'b1;
  logic a_run = 1'b0;
  logic b_run = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic [15:0] q;
  logic pin_o, pin_oe_o, irq_o, pin_line, fault_n;
  ocpwm_tmr_t tmr_a = '0;
  ocpwm_tmr_t tmr_b = '0;
  int n_errors = 0;
  int tests_run = 0;

  // The clock runs at 200 MHz.
  always #2.5 mclk_i = ~mclk_i;

  function automatic logic [15:0] nx(input ocpwm_tmr_t t, input logic r);
    return (!r || t.count == t.period) ? 16'h0000 : t.count + 16'h0001;
  endfunction : nx

  // Both timers count to their period and restart; stopping clears them.
  always @(posedge mclk_i) begin
    tmr_a <= '{nx(tmr_a, a_run), 16'h0064, a_run};
    tmr_b <= '{nx(tmr_b, b_run), 16'h0030, b_run};
  end

  ocpwm_chan ocpwm_chan_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .tmr_a_i(tmr_a), .tmr_b_i(tmr_b), .fault_n_i(fault_n),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o)
  );

  ocpwm_load ocpwm_load_i (
    .mclk_i(mclk_i), .pin_i(pin_o), .oe_i(pin_oe_o), .flt_i(flt),
    .line_o(pin_line), .fault_n_o(fault_n)
  );

  task chk(input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("[FAIL] %0t saw %h expected %h", $time, s, e);
    end
  endtask : chk

  // A write is one strobe cycle; a gap cycle follows so strobes never clash.
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  // Read data is valid only in the cycle after the strobe.
  task rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask : rd

  // Wait for a count on one timer, then let the two-edge pin latency pass.
  task at(input bit b, input logic [15:0] v);
    int k;
    k = 0;
    while (((b ? tmr_b.count : tmr_a.count) !== v) && k < 400) begin
      @(posedge mclk_i);
      #1;
      k++;
    end
    // A count that never shows up would otherwise pass silently.
    if (k >= 400) begin
      n_errors++;
      $display("[FAIL] %0t timer never reached %h", $time, v);
    end
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : at

  task pc(input logic e);
    chk({14'h0000, pin_oe_o, pin_line}, {14'h0000, 1'b1, e});
  endtask : pc

  task oe0();
    chk({15'h0000, pin_oe_o}, 16'h0000);
  endtask : oe0

  task fin(input string s);
    $display("test %s done, %0d errors so far", s, n_errors);
  endtask : fin

  task wrap_up();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // A hung wait is cut short well beyond the few thousand cycles needed.
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  // Main sequence of tests.
  initial begin
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    for (int a = 0; a < 7; a++) begin
      rd(4'(a), q);
      chk(q, 16'h0000);
    end
    oe0();
    @(posedge mclk_i) a_run <= 1'b1;
    fin("reset");
    wr(4'h1, 16'h000a);
    wr(4'h0, 16'h0002);
    at(0, 16'h0014); pc(1'b1);
    wr(4'h1, 16'h001e);
    wr(4'h0, 16'h0001);
    at(0, 16'h0028); pc(1'b0);
    wr(4'h1, 16'h0032);
    wr(4'h0, 16'h0003);
    at(0, 16'h003c); pc(1'b1);
    at(0, 16'h003c); pc(1'b0);
    wr(4'h1, 16'h00c8);
    wr(4'h0, 16'h0002);
    at(0, 16'h005a);
    at(0, 16'h005a); pc(1'b0);
    fin("simple");
    // Second timer selected but stopped: the first timer must not match.
    wr(4'h1, 16'h000a);
    wr(4'h0, 16'h000a);
    rd(4'h0, q); chk(q, 16'h000a);
    at(0, 16'h0032);
    at(0, 16'h0032); pc(1'b0);
    @(posedge mclk_i) b_run <= 1'b1;
    at(1, 16'h0014); pc(1'b1);
    @(posedge mclk_i) b_run <= 1'b0;
    fin("select");
    // Single pulse set up with the timer stopped, period above stop time.
    @(posedge mclk_i) a_run <= 1'b0;
    wr(4'h2, 16'h0014);
    wr(4'h1, 16'h000a);
    wr(4'h0, 16'h0004);
    @(posedge mclk_i) a_run <= 1'b1;
    at(0, 16'h000f); pc(1'b1);
    at(0, 16'h0019); pc(1'b0);
    at(0, 16'h000f); pc(1'b0);
    wr(4'h0, 16'h0004);
    at(0, 16'h000f); pc(1'b1);
    at(0, 16'h0019); pc(1'b0);
    fin("single");
    wr(4'h0, 16'h0005);
    for (int i = 0; i < 2; i++) begin
      at(0, 16'h000f); pc(1'b1);
      at(0, 16'h0019); pc(1'b0);
    end
    fin("continuous");
    // PWM: duty latched at period match, so a mid-period change waits.
    // The timer is stopped while the channel is set up, then run.
    @(posedge mclk_i) a_run <= 1'b0;
    wr(4'h2, 16'h0028);
    wr(4'h0, 16'h0006);
    @(posedge mclk_i) a_run <= 1'b1;
    at(0, 16'h000a);
    at(0, 16'h000a); pc(1'b1);
    at(0, 16'h0032); pc(1'b0);
    wr(4'h1, 16'h0046);
    rd(4'h1, q); chk(q, 16'h0028);
    at(0, 16'h0002);
    wr(4'h2, 16'h003c);
    at(0, 16'h002d); pc(1'b0);
    at(0, 16'h0037); pc(1'b0);
    at(0, 16'h0037); pc(1'b1);
    at(0, 16'h0041); pc(1'b0);
    @(posedge mclk_i) flt <= 1'b1;
    at(0, 16'h000a); pc(1'b1);
    @(posedge mclk_i) flt <= 1'b0;
    fin("pwm");
    // Fault mode: release needs both a quiet fault line and a rewrite.
    wr(4'h2, 16'h0028);
    wr(4'h0, 16'h0007);
    at(0, 16'h000a); pc(1'b1);
    @(posedge mclk_i) flt <= 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    oe0();
    rd(4'h0, q); chk(q, 16'h0017);
    wr(4'h0, 16'h0007);
    at(0, 16'h000a); oe0();
    @(posedge mclk_i) flt <= 1'b0;
    at(0, 16'h000a); oe0();
    wr(4'h0, 16'h0007);
    at(0, 16'h000a); pc(1'b1);
    fin("fault");
    // The sticky fault event drives the interrupt only while unmasked.
    chk({15'h0000, irq_o}, 16'h0000);
    wr(4'h4, 16'h0004);
    rd(4'h4, q); chk(q, 16'h0004);
    chk({15'h0000, irq_o}, 16'h0001);
    wr(4'h3, 16'h0004);
    rd(4'h3, q); chk(q & 16'h0004, 16'h0000);
    chk(q & 16'h0002, 16'h0002);
    chk({15'h0000, irq_o}, 16'h0000);
    // With the enable low all state freezes, so this mask write is lost.
    @(posedge mclk_i) ce <= 1'b0;
    wr(4'h4, 16'h0000);
    @(posedge mclk_i) ce <= 1'b1;
    rd(4'h4, q); chk(q, 16'h0004);
    fin("interrupt");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
